// ---- verilog/bpm_pkg.sv ----
// package: constants, types and structs for the button parameter menu
package bpm_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ       = 25_000_000;
	localparam int unsigned HOLD_S       = 10;
	localparam int unsigned HOLD_CYC     = HOLD_S * CLK_HZ;
	localparam int unsigned DEBOUNCE_US  = 10_000;
	localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
	localparam int unsigned FLASH_MS     = 500;
	localparam int unsigned FLASH_CYC    = FLASH_MS * (CLK_HZ / 1000);

	// ****************************************
	// parameter menu
	// ****************************************
	localparam int unsigned NPAR  = 10;
	localparam logic [3:0]  PIDX_MOTOR = 4'h1;
	localparam logic [3:0]  PIDX_JOY   = 4'h9;
	localparam logic [3:0]  VAL_DASH   = 4'hf;

	// display glyph codes, decoded to segments outside
	localparam logic [4:0] GLY_STEADY = 5'h1e;
	localparam logic [4:0] GLY_CAL    = 5'h1d;
	localparam logic [4:0] GLY_BLANK  = 5'h1f;
	localparam logic [4:0] GLY_DIGIT0 = 5'h00;

	typedef enum logic [6:0] {
		BPM_ST_HOLD   = 7'h01,
		BPM_ST_NORMAL = 7'h02,
		BPM_ST_PROG   = 7'h04,
		BPM_ST_CAL    = 7'h08,
		BPM_ST_SELF   = 7'h10,
		BPM_ST_DEFLT  = 7'h20,
		BPM_ST_DONE   = 7'h40
	} bpm_state_t;

	typedef struct packed {
		logic       we;
		logic [3:0] idx;
		logic [3:0] val;
	} bpm_pwr_t;

	typedef struct packed {
		logic       we;
		logic [7:0] min0;
		logic [7:0] max0;
		logic [7:0] ctr0;
		logic [7:0] min1;
		logic [7:0] max1;
		logic [7:0] ctr1;
	} bpm_cal_t;

endpackage

// ---- verilog/bpm_menu.sv ----
// button parameter menu: hold-at-reset entry, value edit, joystick calibration
`timescale 1ns/1ps

module bpm_menu #(
	parameter int unsigned HOLD_CYC     = bpm_pkg::HOLD_CYC,
	parameter int unsigned DEBOUNCE_CYC = bpm_pkg::DEBOUNCE_CYC,
	parameter int unsigned FLASH_CYC    = bpm_pkg::FLASH_CYC
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic             prog_btn,
	input  wire logic             set_btn,
	input  wire logic [7:0]       joy_ch0,
	input  wire logic [7:0]       joy_ch1,
	input  wire logic [39:0]      nv_values,
	output logic [4:0]            disp_glyph,
	output logic                  run_normal,
	output logic                  self_test,
	output logic                  defaults_we,
	output bpm_pkg::bpm_pwr_t     par_wr,
	output bpm_pkg::bpm_cal_t     cal_wr
);

	// ****************************************
	// parameter tables
	// ****************************************
	localparam logic [3:0] MAXV [bpm_pkg::NPAR] =
		'{4'h3, 4'h1, 4'h5, 4'h5, 4'h2, 4'h1, 4'h7, 4'h4, 4'h4, 4'h0};
	localparam logic [4:0] LETTER [bpm_pkg::NPAR] =
		'{5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19};

	// ****************************************
	// input sync and debounce
	// ****************************************
	logic [1:0] s1_q, s2_q, db_q, db_prev_q;
	logic [1:0] press;
	logic [31:0] dbc_q [2];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_btn
			wire logic raw = (gi == 0) ? prog_btn : set_btn;
			always_ff @(posedge mclk) begin // no reset: a button held through reset counts
				if (clk_en) begin
					s1_q[gi] <= raw;
					s2_q[gi] <= s1_q[gi];
				end
			end
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					db_q[gi]      <= 1'b0;
					db_prev_q[gi] <= 1'b0;
					dbc_q[gi]     <= 32'h0;
				end else if (clk_en) begin
					db_prev_q[gi] <= db_q[gi];
					// a level must stand a full window before it counts
					if (s2_q[gi] == db_q[gi]) begin
						dbc_q[gi] <= 32'h0;
					end else if (dbc_q[gi] >= DEBOUNCE_CYC - 1) begin
						db_q[gi]  <= s2_q[gi];
						dbc_q[gi] <= 32'h0;
					end else begin
						dbc_q[gi] <= dbc_q[gi] + 32'h1;
					end
				end
			end
			assign press[gi] = db_q[gi] & ~db_prev_q[gi];
		end
	endgenerate

	wire logic prog_press = press[0];
	wire logic set_press  = press[1];
	// the raw synced level is used during hold so a debounce lag is not counted
	wire logic prog_lvl   = s2_q[0];
	wire logic set_lvl    = s2_q[1];

	// ****************************************
	// state
	// ****************************************
	bpm_pkg::bpm_state_t st_q, st_d;
	logic [31:0] hold_q;
	logic [1:0]  held_q;
	logic [3:0]  pidx_q;
	logic [3:0]  val_q;
	logic        dirty_q;
	logic [31:0] fl_q;
	logic        fl_phase_q;
	logic [7:0]  mn0_q, mx0_q, mn1_q, mx1_q;

	wire logic [1:0] held_now = {set_lvl, prog_lvl};
	wire logic       hold_done = hold_q >= HOLD_CYC - 1;
	wire logic       hold_lost = hold_q != 32'h0 && (held_now != held_q || held_q == 2'b00);
	wire logic [3:0] cur_max   = MAXV[pidx_q];
	wire logic       is_joy    = pidx_q == bpm_pkg::PIDX_JOY;
	wire logic [3:0] next_idx  = (pidx_q == 4'(bpm_pkg::NPAR - 1)) ? 4'h0 : pidx_q + 4'h1;
	wire logic [3:0] inc_val   = (val_q >= cur_max) ? 4'h0 : val_q + 4'h1;
	wire logic [3:0] next_val  = nv_values[next_idx * 4 +: 4];

	always_comb begin
		st_d = st_q;
		case (st_q)
			bpm_pkg::BPM_ST_HOLD: begin
				if (hold_lost) st_d = bpm_pkg::BPM_ST_NORMAL;
				else if (hold_done) begin
					case (held_q)
						2'b01:   st_d = bpm_pkg::BPM_ST_PROG;
						2'b10:   st_d = bpm_pkg::BPM_ST_SELF;
						default: st_d = bpm_pkg::BPM_ST_DEFLT;
					endcase
				end
			end
			bpm_pkg::BPM_ST_PROG:   if (set_press && is_joy) st_d = bpm_pkg::BPM_ST_CAL;
			bpm_pkg::BPM_ST_CAL:    if (prog_press) st_d = bpm_pkg::BPM_ST_PROG;
			bpm_pkg::BPM_ST_DEFLT:  st_d = bpm_pkg::BPM_ST_DONE;
			bpm_pkg::BPM_ST_NORMAL: st_d = bpm_pkg::BPM_ST_NORMAL;
			bpm_pkg::BPM_ST_SELF:   st_d = bpm_pkg::BPM_ST_SELF;
			bpm_pkg::BPM_ST_DONE:   st_d = bpm_pkg::BPM_ST_DONE;
			default:                st_d = bpm_pkg::BPM_ST_NORMAL;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= bpm_pkg::BPM_ST_HOLD;
			hold_q <= 32'h0;
			held_q <= 2'b00;
		end else if (clk_en) begin
			st_q <= st_d;
			if (st_q == bpm_pkg::BPM_ST_HOLD) begin
				hold_q <= hold_q + 32'h1;
				if (hold_q == 32'h0) held_q <= held_now;
			end
		end
	end

	// ****************************************
	// menu value, edit flag, calibration capture
	// ****************************************
	wire logic enter_prog = st_q == bpm_pkg::BPM_ST_HOLD && st_d == bpm_pkg::BPM_ST_PROG;
	wire logic adv        = st_q == bpm_pkg::BPM_ST_PROG && prog_press;
	wire logic incr       = st_q == bpm_pkg::BPM_ST_PROG && set_press && !is_joy;
	wire logic cal_start  = st_q == bpm_pkg::BPM_ST_PROG && st_d == bpm_pkg::BPM_ST_CAL;
	wire logic cal_save   = st_q == bpm_pkg::BPM_ST_CAL && prog_press;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pidx_q  <= 4'h0;
			val_q   <= 4'h0;
			dirty_q <= 1'b0;
		end else if (clk_en) begin
			if (enter_prog) begin
				pidx_q <= 4'h0;
				val_q  <= nv_values[3:0];
			end else if (adv || cal_save) begin
				pidx_q  <= next_idx;
				val_q   <= next_val;
				dirty_q <= 1'b0;
			end else if (incr) begin
				val_q   <= inc_val;
				dirty_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mn0_q <= 8'hff;
			mx0_q <= 8'h00;
			mn1_q <= 8'hff;
			mx1_q <= 8'h00;
		end else if (clk_en) begin
			if (cal_start) begin
				mn0_q <= joy_ch0;
				mx0_q <= joy_ch0;
				mn1_q <= joy_ch1;
				mx1_q <= joy_ch1;
			end else if (st_q == bpm_pkg::BPM_ST_CAL) begin
				if (joy_ch0 < mn0_q) mn0_q <= joy_ch0;
				if (joy_ch0 > mx0_q) mx0_q <= joy_ch0;
				if (joy_ch1 < mn1_q) mn1_q <= joy_ch1;
				if (joy_ch1 > mx1_q) mx1_q <= joy_ch1;
			end
		end
	end

	// ****************************************
	// write strobes; the running config reads flash only at reset
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			par_wr      <= '0;
			cal_wr      <= '0;
			defaults_we <= 1'b0;
		end else if (clk_en) begin
			par_wr.we   <= adv && dirty_q;
			par_wr.idx  <= pidx_q;
			par_wr.val  <= val_q;
			cal_wr.we   <= cal_save;
			cal_wr.min0 <= mn0_q;
			cal_wr.max0 <= mx0_q;
			cal_wr.ctr0 <= joy_ch0;
			cal_wr.min1 <= mn1_q;
			cal_wr.max1 <= mx1_q;
			cal_wr.ctr1 <= joy_ch1;
			defaults_we <= st_q == bpm_pkg::BPM_ST_DEFLT;
		end
	end

	// ****************************************
	// display: alternate letter and value, or letter and CAL glyph in calibration, no blank between
	// ****************************************
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fl_q       <= 32'h0;
			fl_phase_q <= 1'b0;
		end else if (clk_en) begin
			if (enter_prog || adv || cal_start || cal_save || fl_q >= FLASH_CYC - 1) begin
				fl_q       <= 32'h0;
				fl_phase_q <= (enter_prog || adv || cal_start || cal_save) ? 1'b0 : ~fl_phase_q;
			end else begin
				fl_q <= fl_q + 32'h1;
			end
		end
	end

	wire logic [4:0] val_glyph = (is_joy) ? {1'b0, bpm_pkg::VAL_DASH}
		: bpm_pkg::GLY_DIGIT0 + {1'b0, val_q};
	wire logic [4:0] prog_glyph = fl_phase_q ? val_glyph : LETTER[pidx_q];
	wire logic [4:0] cal_glyph  = fl_phase_q ? bpm_pkg::GLY_CAL : LETTER[pidx_q];
	wire logic [4:0] glyph_d    =
		(st_q == bpm_pkg::BPM_ST_HOLD && held_q != 2'b00) ? bpm_pkg::GLY_STEADY :
		(st_q == bpm_pkg::BPM_ST_PROG) ? prog_glyph :
		(st_q == bpm_pkg::BPM_ST_CAL)  ? cal_glyph : bpm_pkg::GLY_BLANK;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			disp_glyph <= bpm_pkg::GLY_BLANK;
			run_normal <= 1'b0;
			self_test  <= 1'b0;
		end else if (clk_en) begin
			disp_glyph <= glyph_d;
			run_normal <= st_q == bpm_pkg::BPM_ST_NORMAL;
			self_test  <= st_q == bpm_pkg::BPM_ST_SELF;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	prog_stays_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st_q == bpm_pkg::BPM_ST_PROG |=> st_q inside {bpm_pkg::BPM_ST_PROG, bpm_pkg::BPM_ST_CAL})
		else $error("left programming without reset");
	write_clean_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_en && adv && !dirty_q |=> !par_wr.we)
		else $error("write without edit");
	wrap_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_en && incr && val_q == cur_max |=> val_q == 4'h0)
		else $error("value did not wrap");
	val_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st_q == bpm_pkg::BPM_ST_PROG && pidx_q == bpm_pkg::PIDX_MOTOR && dirty_q |-> val_q <= 4'h1)
		else $error("motor mode beyond open loop");
	cal_order_a: assert property (@(posedge mclk) disable iff (!rst_n)
		st_q == bpm_pkg::BPM_ST_CAL && $past(st_q) == bpm_pkg::BPM_ST_CAL
		|-> mn0_q <= mx0_q && mn1_q <= mx1_q)
		else $error("calibration min above max");
	cal_save_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_en && cal_save |=> cal_wr.we && cal_wr.ctr0 == $past(joy_ch0))
		else $error("calibration not saved");
	steady_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_en && st_q == bpm_pkg::BPM_ST_HOLD && held_q == 2'b01
		|=> disp_glyph == bpm_pkg::GLY_STEADY)
		else $error("hold pattern missing");
	early_rel_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_en && st_q == bpm_pkg::BPM_ST_HOLD && hold_q != 32'h0 && hold_lost
		|=> st_q == bpm_pkg::BPM_ST_NORMAL)
		else $error("release did not abandon entry");
	one_press_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clk_en && press[0] |=> !press[0])
		else $error("double press pulse");

endmodule

// ---- verif/bpm_operator.sv ----
// operator model: a person pushing the two front-panel buttons
`timescale 1ns/1ps
module bpm_operator #(
	parameter int unsigned DEB = 4
) (
	input  wire logic mclk,
	output logic      prog_btn,
	output logic      set_btn
);
	// ****************************************
	// button levels
	// ****************************************
	// released buttons read low through their pull-downs
	initial begin
		prog_btn = 1'b0;
		set_btn  = 1'b0;
	end

	task automatic hold(input logic p, input logic s);
		@(posedge mclk);
		#1;
		prog_btn = p;
		set_btn  = s;
	endtask

	// press and release each last well past the debounce window
	task automatic press(input logic p);
		repeat (3 * DEB) @(posedge mclk);
		#1;
		prog_btn = p | prog_btn;
		set_btn  = ~p | set_btn;
		repeat (3 * DEB) @(posedge mclk);
		#1;
		prog_btn = 1'b0;
		set_btn  = 1'b0;
		repeat (3 * DEB) @(posedge mclk);
	endtask
endmodule

// ---- verif/bpm_menu_tb.sv ----
// self-checking bench for the button parameter menu
`timescale 1ns/1ps
module bpm_menu_tb;
	localparam int unsigned HC = 200;
	localparam int unsigned DC = 4;
	logic              mclk = 1'b0;
	logic              rst_n;
	logic              clk_en = 1'b1;
	logic [39:0]       nv_values = 40'h0000000012;
	logic              prog_btn;
	logic              set_btn;
	logic [7:0]        joy_ch0;
	logic [7:0]        joy_ch1;
	logic [4:0]        disp_glyph;
	logic              run_normal;
	logic              self_test;
	logic              defaults_we;
	bpm_pkg::bpm_pwr_t par_wr;
	bpm_pkg::bpm_cal_t cal_wr;
	bpm_pkg::bpm_pwr_t last_wr;
	bpm_pkg::bpm_cal_t last_cal;
	int                n_errors = 0;
	int                check_count = 0;
	int                cyc = 0;
	int                wr_n = 0;
	int                cal_n = 0;
	int                dfl_n = 0;
	int                w0;
	int                d0;
	// rows: prog, set, early release, then normal, self-test, defaults
	logic [5:0]        rows[5] = '{6'h04, 6'h2c, 6'h12, 6'h31, 6'h1c};
	logic [15:0]       jseq[4] = '{16'h8080, 16'h1020, 16'hf0e0, 16'h7090};

	always #20 mclk = ~mclk;

	bpm_operator #(.DEB(DC)) i_bpm_operator (
		.mclk     (mclk),
		.prog_btn (prog_btn),
		.set_btn  (set_btn)
	);

	bpm_menu #(.HOLD_CYC(HC), .DEBOUNCE_CYC(DC), .FLASH_CYC(16)) i_bpm_menu (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.clk_en      (clk_en),
		.prog_btn    (prog_btn),
		.set_btn     (set_btn),
		.joy_ch0     (joy_ch0),
		.joy_ch1     (joy_ch1),
		.nv_values   (nv_values),
		.disp_glyph  (disp_glyph),
		.run_normal  (run_normal),
		.self_test   (self_test),
		.defaults_we (defaults_we),
		.par_wr      (par_wr),
		.cal_wr      (cal_wr)
	);

	// ****************************************
	// strobe capture and hang guard
	// ****************************************
	always @(posedge mclk) begin
		cyc++;
		if (par_wr.we === 1'b1) begin
			wr_n++;
			last_wr = par_wr;
		end
		if (cal_wr.we === 1'b1) begin
			cal_n++;
			last_cal = cal_wr;
		end
		if (defaults_we === 1'b1)
			dfl_n++;
		if (cyc == 8000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reset_with(input logic p, input logic s);
		i_bpm_operator.hold(p, s);
		rst_n = 1'b0;
		repeat (12) @(posedge mclk);
		chk({disp_glyph, run_normal, self_test, defaults_we}, {bpm_pkg::GLY_BLANK, 3'h0});
		#1;
		rst_n = 1'b1;
	endtask

	task automatic wait_g(input logic [4:0] g, input int n);
		int k;
		k = 0;
		while (disp_glyph !== g && k < n) begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk(disp_glyph, g);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_n = 1'b0;
		joy_ch0 = 8'h80;
		joy_ch1 = 8'h80;
		for (int i = 0; i < 5; i++) begin
			reset_with(rows[i][5], rows[i][4]);
			d0 = dfl_n;
			repeat (50) @(posedge mclk);
			if (rows[i][5:4] == 2'h2) chk(disp_glyph, bpm_pkg::GLY_STEADY);
			if (rows[i][3]) i_bpm_operator.hold(1'b0, 1'b0);
			repeat (HC + 20) @(posedge mclk);
			chk({run_normal, self_test, dfl_n - d0 == 1}, rows[i][2:0]);
			$display("entry row %0d done", i);
		end
		reset_with(1'b1, 1'b0);
		wait_g(5'h10, HC + 60);
		wait_g(5'h02, 60);
		i_bpm_operator.hold(1'b0, 1'b0);
		w0 = wr_n;
		i_bpm_operator.press(1'b0);
		wait_g(5'h03, 60);
		i_bpm_operator.press(1'b1);
		chk({wr_n - w0 == 1, last_wr}, {1'b1, 1'b1, 4'h0, 4'h3});
		wait_g(5'h11, 80);
		i_bpm_operator.press(1'b0);
		wait_g(5'h00, 60);
		i_bpm_operator.press(1'b1);
		chk({wr_n - w0 == 2, last_wr}, {1'b1, 1'b1, 4'h1, 4'h0});
		for (int i = 0; i < 7; i++)
			i_bpm_operator.press(1'b1);
		chk(wr_n - w0, 2);
		wait_g(5'h19, 80);
		wait_g({1'b0, bpm_pkg::VAL_DASH}, 60);
		i_bpm_operator.press(1'b0);
		wait_g(bpm_pkg::GLY_CAL, 60);
		foreach (jseq[i]) begin
			@(posedge mclk);
			#1;
			{joy_ch0, joy_ch1} = jseq[i];
			repeat (3) @(posedge mclk);
		end
		d0 = cal_n;
		i_bpm_operator.press(1'b1);
		chk(cal_n - d0, 1);
		chk(last_cal[47:0], 48'h10f07020e090);
		i_bpm_operator.press(1'b1);
		chk({run_normal, self_test}, 2'h0);
		// a press while the clock enable is low must leave no trace
		@(posedge mclk);
		#1;
		clk_en = 1'b0;
		d0 = disp_glyph;
		i_bpm_operator.press(1'b0);
		chk(disp_glyph, d0);
		#1;
		clk_en = 1'b1;
		w0 = wr_n;
		i_bpm_operator.press(1'b0);
		reset_with(1'b0, 1'b0);
		repeat (20) @(posedge mclk);
		chk(wr_n - w0, 0);
		$display("programming test done");
		final_report();
	end
endmodule
